/* File: inc/tdm_ctl_params.svh */
// Constants of the connection memory and tristate control block
`ifndef TDM_CTL_PARAMS_SVH
`define TDM_CTL_PARAMS_SVH

// ==========================================================
// Register port geometry
`define REG_AW 16
`define REG_DW 16
`define REG_SEL_HI 15
`define REG_SEL_LO 13
`define SEL_REGS 3'h0
`define SEL_BP_CM 3'h1
`define SEL_LOC_LO 3'h2
`define SEL_LOC_HI 3'h3

// ==========================================================
// Register offsets inside the register region
`define OFS_CTRL 13'h0000
`define OFS_LOC_RATE 13'h0001
`define OFS_STATUS 13'h0002
`define OFS_LOC_BER_SEL 13'h0027
`define OFS_LOC_BER_RES 13'h0028
`define OFS_BP_BER_SEL 13'h0029
`define OFS_BP_BER_RES 13'h002A

// ==========================================================
// Reset values
`define CTRL_RST 16'h0000
`define LOC_RATE_RST 16'hFC00
`define BER_SEL_RST 13'h0000
`define LFSR_SEED 15'h7FFF

// ==========================================================
// Field positions
`define ENT_MODE_HI 15
`define ENT_MODE_LO 13
`define ENT_SRC_HI 12
`define ENT_STREAM_LO 8
`define CTRL_BP16_BIT 0
`define CTRL_SR_HI 2
`define CTRL_SR_LO 1

// ==========================================================
// Frame geometry and timing counts, in link clock cycles
`define CM_DEPTH 4096
`define BP_LEAD 12'h024
`define LOC_LEAD 12'h020

`endif

/* File: inc/tdm_ctl_pkg.sv */
// Types shared by the connection memory and tristate control block
package tdm_ctl_pkg;

    typedef enum logic [2:0] {
        CM_CONN_VAR = 3'h0,
        CM_CONN_CONST = 3'h1,
        CM_MSG_VAR = 3'h2,
        CM_MSG_CONST = 3'h3,
        CM_BER = 3'h4,
        CM_HIZ = 3'h6
    } chan_mode_t;

    typedef enum logic [1:0] {
        RATE_8M = 2'h0,
        RATE_4M = 2'h1,
        RATE_2M = 2'h2,
        RATE_OFF = 2'h3
    } rate_t;

    typedef enum logic [1:0] {
        SR_OFF = 2'h0,
        SR_2BIT = 2'h1,
        SR_4BIT = 2'h2
    } subrate_t;

    // Gray coded along idle, fetch, source, ready
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_FETCH = 2'b01,
        PH_SRC = 2'b11,
        PH_READY = 2'b10
    } pipe_state_t;

endpackage : tdm_ctl_pkg

/* File: rtl/tdm_connection_memory_tristate_ctl.sv */
// Connection memories, channel output control, BER test and tristate control streams
//
// Contract
// - One backplane memory entry per backplane channel configures that output slot.
// - Backplane three-bit mode picks message/connection, delay, high-impedance or BER.
// - Backplane switching takes the slot from entry source stream and channel.
// - Backplane message mode drives the entry's low eight bits.
// - Local memory has low and high parts, one location per output channel.
// - Local three-bit mode picks message/connection, delay, high-impedance or BER.
// - Local switching takes the slot from low-part source stream and channel.
// - Local message mode drives the low part's low eight bits.
// - Sub-rate position in the high part selects which input bits go out.
// - Each interface has its own 2^15-1 pattern transmitter, placed by memory.
// - Each BER receiver listens to the channel its input select register names.
// - Receiver comparison result lands in that interface's BER result register.
// - Two serial tristate control streams, 4096 bits per frame, one per channel.
// - Control bit high means channel high impedance; low means active data.
// - Backplane control bit zero leads the frame boundary by 36 clocks.
// - Local control stream has 128 slots of 32 bit positions.
// - Local slot zero's first bit leads the frame boundary by 32 clocks.
// - Local streams at 8 Mb/s: slot n carries channel n.
// - Local streams at 4 Mb/s: only even slots carry control bits.
// - Local streams at 2 Mb/s: only every fourth slot carries control bits.
// - Mixed rates: each position follows its own stream's rate.
// - Backplane mode 110 puts that channel into input mode, driver off.
// - Local mode 110 forces that output channel high impedance.
// - Drive enable pin low: everything high impedance regardless of memory.
`timescale 1ns/100ps
`default_nettype none
`include "tdm_ctl_params.svh"

module tdm_connection_memory_tristate_ctl
    import tdm_ctl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [`REG_AW-1:0] reg_addr_i,
    input wire logic [`REG_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`REG_DW-1:0] reg_rdata_o,
    input wire logic fast_output_clock_i,
    input wire logic frame_sync_n_i,
    input wire logic output_drive_enable_i,
    output logic [12:0] bp_src_addr_o,
    input wire logic [7:0] bp_src_data_i,
    output logic [12:0] loc_src_addr_o,
    input wire logic [7:0] loc_src_data_i,
    output logic [7:0] bp_out_byte_o,
    output logic [11:0] bp_out_index_o,
    output logic bp_out_valid_o,
    output logic [7:0] loc_out_byte_o,
    output logic [11:0] loc_out_index_o,
    output logic loc_out_valid_o,
    input wire logic [7:0] bp_rx_byte_i,
    input wire logic [12:0] bp_rx_chan_i,
    input wire logic bp_rx_valid_i,
    input wire logic [7:0] loc_rx_byte_i,
    input wire logic [12:0] loc_rx_chan_i,
    input wire logic loc_rx_valid_i,
    output logic bp_tristate_ctrl_out_o,
    output logic loc_tristate_ctrl_out_o
);

    // ==========================================================
    // Functions

    function automatic logic [2:0] region(input logic [`REG_AW-1:0] a);
        region = a[`REG_SEL_HI:`REG_SEL_LO];
    endfunction : region

    // Backplane memory is stored in control bit order, so the stream walk needs no mapping
    function automatic logic [11:0] bp_index(input logic [12:0] sc, input logic rate16);
        if (rate16) begin
            bp_index = {sc[7:0], sc[11:8]};
        end else begin
            bp_index = {sc[6:0], sc[12:8]};
        end
    endfunction : bp_index

    function automatic logic [11:0] loc_index(input logic [12:0] sc);
        loc_index = {sc[6:0], sc[12:8]};
    endfunction : loc_index

    // Returns dummy flag and channel for a slot at the given stream rate
    function automatic logic [7:0] loc_map(input logic [6:0] slot, input logic [1:0] rate);
        case (rate)
            RATE_8M: loc_map = {1'b0, slot};
            RATE_4M: loc_map = {slot[0], 1'b0, slot[6:1]};
            RATE_2M: loc_map = {|slot[1:0], 2'b00, slot[6:2]};
            default: loc_map = {1'b1, 7'h00};
        endcase
    endfunction : loc_map

    // Eight steps of the x^15 + x^14 + 1 generator: {byte, new state}
    function automatic logic [22:0] prbs8(input logic [14:0] seed);
        logic [14:0] s;
        logic [7:0] b;
        logic fb;
        s = seed;
        b = 8'h00;
        for (int i = 0; i < 8; i++) begin
            fb = s[14] ^ s[13];
            s = {s[13:0], fb};
            b = {b[6:0], fb};
        end
        prbs8 = {b, s};
    endfunction : prbs8

    // Self-synchronising check of one byte, MSB first: {error count, new state}
    function automatic logic [18:0] ber_check(input logic [14:0] seed, input logic [7:0] d);
        logic [14:0] s;
        logic [3:0] cnt;
        s = seed;
        cnt = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            cnt = cnt + {3'b000, (s[14] ^ s[13]) != d[i]};
            s = {s[13:0], d[i]};
        end
        ber_check = {cnt, s};
    endfunction : ber_check

    function automatic logic [15:0] sat_add(input logic [15:0] acc, input logic [3:0] inc);
        logic [16:0] t;
        t = {1'b0, acc} + {13'h0000, inc};
        sat_add = t[16] ? 16'hFFFF : t[15:0];
    endfunction : sat_add

    function automatic logic [7:0] subrate_pick(input logic [7:0] d, input logic [1:0] sr,
                                                input logic [1:0] pos);
        case (sr)
            SR_2BIT: subrate_pick = {6'h00, d[{pos, 1'b0} +: 2]};
            SR_4BIT: subrate_pick = {4'h0, pos[0] ? d[7:4] : d[3:0]};
            default: subrate_pick = d;
        endcase
    endfunction : subrate_pick

    // ==========================================================
    // Storage and configuration

    logic [15:0] bp_cm [0:`CM_DEPTH-1];
    logic [15:0] loc_lo [0:`CM_DEPTH-1];
    logic [1:0] loc_hi [0:`CM_DEPTH-1];
    logic [15:0] ctrl;
    logic [15:0] loc_rate;
    logic [12:0] bp_ber_sel;
    logic [12:0] loc_ber_sel;
    logic [15:0] bp_ber_res;
    logic [15:0] loc_ber_res;
    logic [14:0] bp_rx_lfsr;
    logic [14:0] loc_rx_lfsr;
    logic [14:0] bp_tx_lfsr;
    logic [14:0] loc_tx_lfsr;

    logic lk_s1, lk_s2, lk_s3;
    logic fr_s1, fr_s2;
    logic ode_s1, ode_s2;
    logic link_rise;
    logic frame_hit;
    pipe_state_t state;
    logic [11:0] bp_pos, loc_pos;
    logic [11:0] bp_look, loc_look;
    logic [11:0] bp_look_q, loc_look_q;
    logic [15:0] bp_entry, loc_entry;
    logic [1:0] loc_srpos;
    logic loc_dummy;
    logic [7:0] loc_slot_map;
    logic [4:0] loc_stream;
    logic reg_hit;
    logic [2:0] sel;
    logic [12:0] ofs;
    logic bp_tri, loc_tri;
    logic bp_emit, loc_emit;
    logic [22:0] bp_prbs, loc_prbs;
    logic [18:0] bp_chk, loc_chk;
    logic [7:0] bp_byte, loc_byte;
    chan_mode_t bp_mode, loc_mode;

    assign sel = region(reg_addr_i);
    assign ofs = reg_addr_i[12:0];
    assign reg_hit = reg_wr_i && sel == `SEL_REGS;

    // Memories carry no reset; software loads them before enabling drive
    always_ff @(posedge mclk_i) begin
        if (reg_wr_i && sel == `SEL_BP_CM) begin
            bp_cm[bp_index(ofs, ctrl[`CTRL_BP16_BIT])] <= reg_wdata_i;
        end
        if (reg_wr_i && sel == `SEL_LOC_LO) begin
            loc_lo[loc_index(ofs)] <= reg_wdata_i;
        end
        if (reg_wr_i && sel == `SEL_LOC_HI) begin
            loc_hi[loc_index(ofs)] <= reg_wdata_i[1:0];
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl <= `CTRL_RST;
            loc_rate <= `LOC_RATE_RST;
            bp_ber_sel <= `BER_SEL_RST;
            loc_ber_sel <= `BER_SEL_RST;
        end else if (reg_hit) begin
            if (ofs == `OFS_CTRL) begin
                ctrl <= reg_wdata_i & 16'h0007;
            end else if (ofs == `OFS_LOC_RATE) begin
                loc_rate <= reg_wdata_i;
            end else if (ofs == `OFS_BP_BER_SEL) begin
                bp_ber_sel <= reg_wdata_i[12:0];
            end else if (ofs == `OFS_LOC_BER_SEL) begin
                loc_ber_sel <= reg_wdata_i[12:0];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (sel == `SEL_BP_CM) begin
            reg_rdata_o <= bp_cm[bp_index(ofs, ctrl[`CTRL_BP16_BIT])];
        end else if (sel == `SEL_LOC_LO) begin
            reg_rdata_o <= loc_lo[loc_index(ofs)];
        end else if (sel == `SEL_LOC_HI) begin
            reg_rdata_o <= {14'h0000, loc_hi[loc_index(ofs)]};
        end else if (sel != `SEL_REGS) begin
            reg_rdata_o <= 16'h0000;
        end else if (ofs == `OFS_CTRL) begin
            reg_rdata_o <= ctrl;
        end else if (ofs == `OFS_LOC_RATE) begin
            reg_rdata_o <= loc_rate;
        end else if (ofs == `OFS_STATUS) begin
            reg_rdata_o <= {13'h0000, ode_s2, state};
        end else if (ofs == `OFS_BP_BER_SEL) begin
            reg_rdata_o <= {3'b000, bp_ber_sel};
        end else if (ofs == `OFS_LOC_BER_SEL) begin
            reg_rdata_o <= {3'b000, loc_ber_sel};
        end else if (ofs == `OFS_BP_BER_RES) begin
            reg_rdata_o <= bp_ber_res;
        end else if (ofs == `OFS_LOC_BER_RES) begin
            reg_rdata_o <= loc_ber_res;
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // ==========================================================
    // BER receivers

    assign bp_chk = ber_check(bp_rx_lfsr, bp_rx_byte_i);
    assign loc_chk = ber_check(loc_rx_lfsr, loc_rx_byte_i);

    // A result write clears the count, but an error counted that cycle still lands
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bp_rx_lfsr <= `LFSR_SEED;
            bp_ber_res <= 16'h0000;
        end else begin
            if (bp_rx_valid_i && bp_rx_chan_i == bp_ber_sel) begin
                bp_rx_lfsr <= bp_chk[14:0];
            end
            if (bp_rx_valid_i && bp_rx_chan_i == bp_ber_sel) begin
                bp_ber_res <= sat_add((reg_hit && ofs == `OFS_BP_BER_RES) ? 16'h0000
                                      : bp_ber_res, bp_chk[18:15]);
            end else if (reg_hit && ofs == `OFS_BP_BER_RES) begin
                bp_ber_res <= 16'h0000;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            loc_rx_lfsr <= `LFSR_SEED;
            loc_ber_res <= 16'h0000;
        end else begin
            if (loc_rx_valid_i && loc_rx_chan_i == loc_ber_sel) begin
                loc_rx_lfsr <= loc_chk[14:0];
            end
            if (loc_rx_valid_i && loc_rx_chan_i == loc_ber_sel) begin
                loc_ber_res <= sat_add((reg_hit && ofs == `OFS_LOC_BER_RES) ? 16'h0000
                                       : loc_ber_res, loc_chk[18:15]);
            end else if (reg_hit && ofs == `OFS_LOC_BER_RES) begin
                loc_ber_res <= 16'h0000;
            end
        end
    end

    // ==========================================================
    // Link clock, frame and drive enable synchronisers

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lk_s1 <= 1'b0;
            lk_s2 <= 1'b0;
            lk_s3 <= 1'b0;
            fr_s1 <= 1'b1;
            fr_s2 <= 1'b1;
            ode_s1 <= 1'b0;
            ode_s2 <= 1'b0;
        end else begin
            lk_s1 <= fast_output_clock_i;
            lk_s2 <= lk_s1;
            lk_s3 <= lk_s2;
            fr_s1 <= frame_sync_n_i;
            fr_s2 <= fr_s1;
            ode_s1 <= output_drive_enable_i;
            ode_s2 <= ode_s1;
        end
    end

    assign link_rise = lk_s2 & ~lk_s3;
    assign frame_hit = link_rise & ~fr_s2;

    // ==========================================================
    // Bit position counters, 4096 positions per frame

    assign bp_look = 12'(bp_pos + 12'h001);
    assign loc_look = 12'(loc_pos + 12'h001);

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bp_pos <= 12'h000;
            loc_pos <= 12'h000;
        end else if (frame_hit) begin
            bp_pos <= `BP_LEAD;
            loc_pos <= `LOC_LEAD;
        end else if (link_rise) begin
            bp_pos <= bp_look;
            loc_pos <= loc_look;
        end
    end

    // ==========================================================
    // Fetch pipeline: the next position is looked up while the current bit is out

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= PH_IDLE;
        end else begin
            case (state)
                PH_IDLE: state <= link_rise ? PH_FETCH : PH_IDLE;
                PH_FETCH: state <= PH_SRC;
                PH_SRC: state <= PH_READY;
                PH_READY: state <= link_rise ? PH_FETCH : PH_READY;
                default: state <= PH_IDLE;
            endcase
        end
    end

    assign loc_stream = loc_look[4:0];
    assign loc_slot_map = loc_map(loc_look[11:5], loc_rate[{loc_stream[4:2], 1'b0} +: 2]);

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bp_entry <= {CM_HIZ, 13'h0000};
            loc_entry <= {CM_HIZ, 13'h0000};
            loc_srpos <= 2'b00;
            loc_dummy <= 1'b1;
            bp_look_q <= 12'h000;
            loc_look_q <= 12'h000;
        end else if (state == PH_FETCH) begin
            bp_entry <= bp_cm[bp_look];
            loc_entry <= loc_lo[{loc_slot_map[6:0], loc_stream}];
            loc_srpos <= loc_hi[{loc_slot_map[6:0], loc_stream}];
            loc_dummy <= loc_slot_map[7];
            bp_look_q <= bp_look;
            loc_look_q <= loc_look;
        end
    end

    // Source address stands until the next fetch; the data memory answers within it
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bp_src_addr_o <= 13'h0000;
            loc_src_addr_o <= 13'h0000;
        end else if (state == PH_SRC) begin
            bp_src_addr_o <= bp_entry[`ENT_SRC_HI:0];
            loc_src_addr_o <= loc_entry[`ENT_SRC_HI:0];
        end
    end

    // ==========================================================
    // Channel output selection

    assign bp_mode = chan_mode_t'(bp_entry[`ENT_MODE_HI:`ENT_MODE_LO]);
    assign loc_mode = chan_mode_t'(loc_entry[`ENT_MODE_HI:`ENT_MODE_LO]);
    assign bp_prbs = prbs8(bp_tx_lfsr);
    assign loc_prbs = prbs8(loc_tx_lfsr);

    // High control bit means high impedance
    assign bp_tri = ~ode_s2 | bp_mode == CM_HIZ;
    assign loc_tri = ~ode_s2 | loc_mode == CM_HIZ | loc_dummy;
    assign bp_emit = link_rise & state == PH_READY & ~bp_tri;
    assign loc_emit = link_rise & state == PH_READY & ~loc_tri;

    always_comb begin
        case (bp_mode)
            CM_MSG_VAR, CM_MSG_CONST: bp_byte = bp_entry[7:0];
            CM_BER: bp_byte = bp_prbs[22:15];
            default: bp_byte = bp_src_data_i;
        endcase
    end

    always_comb begin
        case (loc_mode)
            CM_MSG_VAR, CM_MSG_CONST: loc_byte = loc_entry[7:0];
            CM_BER: loc_byte = loc_prbs[22:15];
            default: loc_byte = subrate_pick(loc_src_data_i, ctrl[`CTRL_SR_HI:`CTRL_SR_LO],
                                             loc_srpos);
        endcase
    end

    // Each generator steps only when its byte actually goes out
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bp_tx_lfsr <= `LFSR_SEED;
            loc_tx_lfsr <= `LFSR_SEED;
        end else begin
            if (bp_emit && bp_mode == CM_BER) begin
                bp_tx_lfsr <= bp_prbs[14:0];
            end
            if (loc_emit && loc_mode == CM_BER) begin
                loc_tx_lfsr <= loc_prbs[14:0];
            end
        end
    end

    // ==========================================================
    // Serial tristate control and slot outputs, changing on link clock edges

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bp_tristate_ctrl_out_o <= 1'b1;
            loc_tristate_ctrl_out_o <= 1'b1;
        end else if (link_rise) begin
            bp_tristate_ctrl_out_o <= state != PH_READY | bp_tri;
            loc_tristate_ctrl_out_o <= state != PH_READY | loc_tri;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bp_out_byte_o <= 8'h00;
            bp_out_index_o <= 12'h000;
            bp_out_valid_o <= 1'b0;
            loc_out_byte_o <= 8'h00;
            loc_out_index_o <= 12'h000;
            loc_out_valid_o <= 1'b0;
        end else begin
            bp_out_valid_o <= bp_emit;
            loc_out_valid_o <= loc_emit;
            if (bp_emit) begin
                bp_out_byte_o <= bp_byte;
                bp_out_index_o <= bp_look_q;
            end
            if (loc_emit) begin
                loc_out_byte_o <= loc_byte;
                loc_out_index_o <= loc_look_q;
            end
        end
    end

endmodule : tdm_connection_memory_tristate_ctl
`default_nettype wire

/* File: test/tdm_ctl_sva.sv */
// Port checker for the tristate control block
`timescale 1ns/100ps
`default_nettype none
module tdm_ctl_chk (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic output_drive_enable_i,
    input wire logic bp_out_valid_o,
    input wire logic loc_out_valid_o,
    input wire logic bp_tristate_ctrl_out_o,
    input wire logic loc_tristate_ctrl_out_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    // ====================
    // Register port
    property p_sel;
        reg_wr_i && reg_addr_i == 16'h0029 ##1 reg_rd_i && reg_addr_i == 16'h0029
            |=> reg_rdata_o == {3'h0, $past(reg_wdata_i[12:0], 2)};
    endproperty
    a_sel: assert property (p_sel) else $error("select readback");
    property p_idle; !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data off slot");
    // ====================
    // Control streams
    property p_bpul; bp_out_valid_o |=> !bp_out_valid_o; endproperty
    a_bpul: assert property (p_bpul) else $error("bp pulse long");
    property p_lpul; loc_out_valid_o |=> !loc_out_valid_o; endproperty
    a_lpul: assert property (p_lpul) else $error("loc pulse long");
    property p_bdrv; bp_out_valid_o |-> !bp_tristate_ctrl_out_o; endproperty
    a_bdrv: assert property (p_bdrv) else $error("bp driven but off");
    property p_ldrv; loc_out_valid_o |-> !loc_tristate_ctrl_out_o; endproperty
    a_ldrv: assert property (p_ldrv) else $error("loc driven but off");
    // One bit per link period, so a bit never lasts under four clocks
    property p_hold;
        $changed(bp_tristate_ctrl_out_o) |=> $stable(bp_tristate_ctrl_out_o)[*3];
    endproperty
    a_hold: assert property (p_hold) else $error("bp bit too short");
    property p_ode;
        (!output_drive_enable_i)[*8] ##1 (!output_drive_enable_i)[*8] ##1
            (!output_drive_enable_i)[*8]
            |-> bp_tristate_ctrl_out_o && loc_tristate_ctrl_out_o && !bp_out_valid_o;
    endproperty
    a_ode: assert property (p_ode) else $error("driven while disabled");
    c_bp: cover property (bp_out_valid_o);
    c_loc: cover property (loc_out_valid_o);
    c_ode: cover property (!output_drive_enable_i ##1 output_drive_enable_i);
endmodule : tdm_ctl_chk
bind tdm_connection_memory_tristate_ctl tdm_ctl_chk chk_u (.mclk_i, .nrst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .output_drive_enable_i, .bp_out_valid_o,
    .loc_out_valid_o, .bp_tristate_ctrl_out_o, .loc_tristate_ctrl_out_o);
`default_nettype wire

/* File: test/tdm_src_model.sv */
// Far side: source channels and a backplane receiver fed by driven slots
`timescale 1ns/100ps
`default_nettype none
module tdm_src_model (
    input wire logic [12:0] bp_addr_i,
    input wire logic [12:0] loc_addr_i,
    input wire logic [7:0] bp_byte_i,
    input wire logic [11:0] bp_idx_i,
    input wire logic bp_vld_i,
    output logic [7:0] bp_data_o,
    output logic [7:0] loc_data_o,
    output logic [7:0] rx_byte_o,
    output logic [12:0] rx_chan_o,
    output logic rx_valid_o
);
    // ====================
    // Each source channel carries a byte made from its own address
    assign bp_data_o = bp_addr_i[7:0] ^ {bp_addr_i[12:8], 3'h5};
    assign loc_data_o = loc_addr_i[7:0] ^ {loc_addr_i[12:8], 3'h5};
    // Only driven slots return, so high-impedance slots never reach the receiver
    assign rx_valid_o = bp_vld_i;
    assign rx_byte_o = bp_byte_i;
    assign rx_chan_o = {bp_idx_i[4:0], 1'b0, bp_idx_i[11:5]};
endmodule : tdm_src_model
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the tristate control block
`timescale 1ns/100ps
`default_nettype none
`include "tdm_ctl_params.svh"
module testbench
    import tdm_ctl_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, lclk = 1'b0, frm_n = 1'b1, output_drive_enable = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
    logic [12:0] bsa, lsa, rxc;
    logic [11:0] bix, lix;
    logic [7:0] bsd, lsd, bby, lby, rxb;
    logic bvl, lvl, rxv, bts, lts;
    int checks = 0, n_mismatch = 0;
    chan_mode_t mt[6] = '{CM_MSG_VAR, CM_CONN_VAR, CM_HIZ, CM_MSG_CONST, CM_CONN_CONST, CM_BER};
    always #25 clk = ~clk;
    initial #7 forever #200 lclk = ~lclk;
    tdm_connection_memory_tristate_ctl dut_u (.mclk_i(clk), .nrst_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .fast_output_clock_i(lclk), .frame_sync_n_i(frm_n), .output_drive_enable_i(output_drive_enable),
        .bp_src_addr_o(bsa), .bp_src_data_i(bsd), .loc_src_addr_o(lsa), .loc_src_data_i(lsd),
        .bp_out_byte_o(bby), .bp_out_index_o(bix), .bp_out_valid_o(bvl), .loc_out_byte_o(lby),
        .loc_out_index_o(lix), .loc_out_valid_o(lvl), .bp_rx_byte_i(rxb), .bp_rx_chan_i(rxc),
        .bp_rx_valid_i(rxv), .loc_rx_byte_i(8'h00), .loc_rx_chan_i(13'h0000),
        .loc_rx_valid_i(1'b0), .bp_tristate_ctrl_out_o(bts), .loc_tristate_ctrl_out_o(lts));
    tdm_src_model far_u (.bp_addr_i(bsa), .loc_addr_i(lsa), .bp_byte_i(bby), .bp_idx_i(bix),
        .bp_vld_i(bvl), .bp_data_o(bsd), .loc_data_o(lsd), .rx_byte_o(rxb), .rx_chan_o(rxc),
        .rx_valid_o(rxv));
    // ====================
    // Helpers
    function automatic logic [12:0] pa(input logic [11:0] p);
        return {p[4:0], 1'b0, p[11:5]};
    endfunction : pa
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Every write is read straight back, strobes back to back
    task automatic rw(input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        q = rdata;
    endtask : rw
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    // ====================
    // One frame pass: k 0 plain, 1 local 4 Mb/s, 2 sub-rate, 3 drive disabled
    task automatic run_pass(input int k);
        logic [15:0] e[6];
        logic [15:0] q;
        logic [1:0] ps[6];
        logic [11:0] p;
        logic [7:0] x;
        logic hz;
        @(posedge clk);
        output_drive_enable <= k != 3;
        rw({`SEL_REGS, `OFS_LOC_RATE}, (k == 1) ? 16'hFC15 : 16'hFC00, q);
        rw({`SEL_REGS, `OFS_CTRL}, (k == 2) ? 16'h0002 : 16'h0000, q);
        for (int i = 0; i < 6; i++) begin
            p = 12'h025 + 12'(i);
            e[i] = {mt[i], 13'($urandom)};
            ps[i] = 2'($urandom);
            for (int r = 1; r < 3; r++) begin
                rw({3'(r), pa(p - 12'(4 * r - 4))}, e[i], q);
                chk(q, e[i]);
            end
            rw({`SEL_LOC_HI, pa(p - 12'h004)}, {14'h0000, ps[i]}, q);
        end
        @(negedge lclk);
        @(posedge clk);
        frm_n <= 1'b0;
        @(negedge lclk);
        @(posedge clk);
        frm_n <= 1'b1;
        @(posedge lclk);
        // The bit seen at a link rise belongs to the position before it
        for (int i = 0; i < 6; i++) begin
            @(posedge lclk);
            p = 12'h025 + 12'(i);
            hz = e[i][15:13] == CM_HIZ || k == 3;
            x = e[i][14] ? e[i][7:0] : (e[i][7:0] ^ {e[i][12:8], 3'h5});
            chk(bts, hz);
            chk(lts, hz || k == 1);
            if (!hz) chk(bix, p);
            if (!hz && !e[i][15]) chk(bby, x);
            if (!hz && k != 1) chk(lix, p - 12'h004);
            if (!hz && !e[i][15] && k == 0) chk(lby, x);
            if (!hz && e[i][15:14] == 2'h0 && k == 2) chk(lby[1:0], 2'(x >> {ps[i], 1'b0}));
        end
        @(posedge clk);
        output_drive_enable <= 1'b1;
    endtask : run_pass
    initial begin
        logic [15:0] q, v;
        void'($urandom(59));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({bts, lts}, 16'h0003);
        for (int p = 0; p < `CM_DEPTH; p++) begin
            rw({`SEL_BP_CM, pa(12'(p))}, 16'hC000, q);
            rw({`SEL_LOC_LO, pa(12'(p))}, 16'hC000, q);
        end
        v = 16'($urandom);
        rw({`SEL_REGS, `OFS_BP_BER_SEL}, v, q);
        chk(q, {3'h0, v[12:0]});
        rw({`SEL_REGS, `OFS_LOC_BER_SEL}, v, q);
        chk(q, {3'h0, v[12:0]});
        rw(16'h8003, v, q);
        chk(q, 16'h0000);
        for (int k = 0; k < 4; k++) run_pass(k);
        print_verdict;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        print_verdict;
    end
endmodule : testbench
`default_nettype wire
